//--- irq_pkg.sv
// shared constants and types for the dual request interrupt controller
package irq_pkg;

    localparam int NUM_SRC = 16;
    localparam int NUM_GPIO = 4;
    localparam int NUM_DEB = 6;
    localparam int DEB_W = 3;

    // source positions inside the flag, mask and raw vectors
    localparam int SRC_JACK1_RISE = 0;
    localparam int SRC_JACK1_FALL = 1;
    localparam int SRC_JACK2_RISE = 2;
    localparam int SRC_JACK2_FALL = 3;
    localparam int SRC_GPIO_LSB = 4;
    localparam int SRC_FLL_LSB = 8;
    localparam int SRC_BOOT = 10;
    localparam int SRC_DSP_LSB = 11;
    localparam int SRC_ACC = 13;
    localparam int SRC_EVLOG_LSB = 14;
    localparam int DEB_FLL_LSB = 4;

    // sources that flag on both edges: gpio and lock inputs
    localparam logic [15:0] BOTH_EDGE_SEL = 16'h03f0;

    // register byte addresses
    localparam logic [7:0] ADDR_FLAG1 = 8'h00;
    localparam logic [7:0] ADDR_MASK1 = 8'h04;
    localparam logic [7:0] ADDR_FLAG2 = 8'h08;
    localparam logic [7:0] ADDR_MASK2 = 8'h0c;
    localparam logic [7:0] ADDR_RAW = 8'h10;
    localparam logic [7:0] ADDR_CTRL = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    // reset values: only boot done unmasked on the first set
    localparam logic [15:0] MASK1_RST = 16'hfbff;
    localparam logic [15:0] MASK2_RST = 16'hffff;
    localparam logic [15:0] FLAG_RST = 16'h0000;
    localparam logic [9:0] CTRL_RST = 10'h000;

    // control register fields
    localparam int CTRL_GM1 = 0;
    localparam int CTRL_GM2 = 1;
    localparam int CTRL_POL = 2;
    localparam int CTRL_OD = 3;
    localparam int CTRL_DEB_LSB = 4;
    localparam int CTRL_GPFN_LSB = 8;

    // gpio pin function select codes
    localparam logic [1:0] GPFN_OFF = 2'h0;
    localparam logic [1:0] GPFN_FIRST = 2'h1;
    localparam logic [1:0] GPFN_SECOND = 2'h2;

    // debounce: filtered level follows after this many stable ticks
    localparam logic [DEB_W-1:0] DEB_TICKS = 3'h4;
    localparam logic [DEB_W-1:0] DEB_ZERO = 3'h0;
    localparam logic [DEB_W-1:0] DEB_ONE = 3'h1;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic                 jack_detect_one;
        logic                 jack_detect_two;
        logic [NUM_GPIO-1:0]  gpio;
        logic [1:0]           fll_lock;
        logic                 boot_done;
        logic [1:0]           signal_processor_request_flags;
        logic                 accessory_detect;
        logic [1:0]           evlog_not_empty;
    } src_in_t;

    typedef struct packed {
        logic [DEB_W-1:0] cnt;
        logic             val;
    } deb_t;

endpackage

//--- irq_ctrl.sv
// dual request interrupt controller with ahb-lite register slave
// Operation
// - two independent flag sets, one per output
// - any input combination can raise either output
// - flags set on rising or both edges
// - both-edge flags do not record edge direction
// - jack detects have separate rise and fall flags
// - raw levels readable, same for both sets
// - raw readback independent of debounce clocks
// - masked input sets no flag, no request
// - each output is OR of own flags
// - flags latch until software writes one
// - output holds until all its flags cleared
// - optional gpio debounce on 32kHz clock
// - lock inputs always debounced, need a clock
// - global mask per output, status bit readable
// - first output drives pin, active low, invertible
// - pin push-pull or open-drain selectable
// - second output triggers signal processor firmware
// - either output selectable onto gpio pin
// - after reset only boot done unmasked
// - event logger not-empty latches a flag
`timescale 1ns/1ps
`default_nettype none

module irq_ctrl
    import irq_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire src_in_t     src_in,
    input  wire logic        clk32k,
    input  wire logic        sysclk_on,
    output logic             first_request_output,
    output logic             second_request_output,
    output logic             irq_pin_out,
    output logic             irq_pin_oe,
    output logic             gpio_req_out,
    output logic             dsp_fw_trigger
);

    // one debounce step: count stable ticks, adopt level at the limit
    function automatic deb_t deb_step(input deb_t cur, input logic raw, input logic tick);
        deb_t nxt;
        nxt = cur;
        if (raw == cur.val) begin
            nxt.cnt = DEB_ZERO;
        end else if (tick) begin
            if (cur.cnt + DEB_ONE == DEB_TICKS) begin
                nxt.val = raw;
                nxt.cnt = DEB_ZERO;
            end else begin
                nxt.cnt = cur.cnt + DEB_ONE;
            end
        end
        return nxt;
    endfunction

    // raw input levels in flag order
    function automatic logic [NUM_SRC-1:0] raw_vec(input src_in_t s);
        logic [NUM_SRC-1:0] v;
        v = '0;
        v[SRC_JACK1_RISE] = s.jack_detect_one;
        v[SRC_JACK1_FALL] = s.jack_detect_one;
        v[SRC_JACK2_RISE] = s.jack_detect_two;
        v[SRC_JACK2_FALL] = s.jack_detect_two;
        v[SRC_GPIO_LSB +: NUM_GPIO] = s.gpio;
        v[SRC_FLL_LSB +: 2] = s.fll_lock;
        v[SRC_BOOT] = s.boot_done;
        v[SRC_DSP_LSB +: 2] = s.signal_processor_request_flags;
        v[SRC_ACC] = s.accessory_detect;
        v[SRC_EVLOG_LSB +: 2] = s.evlog_not_empty;
        return v;
    endfunction

    // unmasked edges set flags; applied after any clear so the set wins
    function automatic logic [NUM_SRC-1:0] set_hits(input logic [NUM_SRC-1:0] cur,
                                                    input logic [NUM_SRC-1:0] hit,
                                                    input logic [NUM_SRC-1:0] mask);
        logic [NUM_SRC-1:0] nxt;
        // masked edges never reach the flag
        nxt = hit & ~mask;
        // new edge wins over a clear
        nxt = cur | nxt;
        return nxt;
    endfunction

    // combined request of one set, gated by its global mask
    function automatic logic set_req(input logic [NUM_SRC-1:0] flags, input logic gmask);
        logic r;
        r = (|flags) & ~gmask;
        return r;
    endfunction

    // ---------------- bus state ----------------
    logic        wr_pend_reg;
    logic        wr_pend_next;
    logic [7:0]  wr_addr_reg;
    logic [7:0]  wr_addr_next;
    logic        rd_pend_reg;
    logic        rd_pend_next;
    logic [7:0]  rd_addr_reg;
    logic [7:0]  rd_addr_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic        hreadyout_reg;
    logic        hreadyout_next;
    logic        hresp_reg;
    logic        hresp_next;

    // ---------------- register state ----------------
    logic [15:0] flag1_reg;
    logic [15:0] flag1_next;
    logic [15:0] flag2_reg;
    logic [15:0] flag2_next;
    logic [15:0] mask1_reg;
    logic [15:0] mask1_next;
    logic [15:0] mask2_reg;
    logic [15:0] mask2_next;
    logic [9:0]  ctrl_reg;
    logic [9:0]  ctrl_next;

    // ---------------- input conditioning state ----------------
    logic [15:0] prev_reg;
    logic [15:0] prev_next;
    logic        clk32_prev_reg;
    logic        clk32_prev_next;
    deb_t        deb_reg [NUM_DEB];
    deb_t        deb_next [NUM_DEB];

    // ---------------- output state ----------------
    logic        req1_reg;
    logic        req1_next;
    logic        req2_reg;
    logic        req2_next;
    logic        pin_out_reg;
    logic        pin_out_next;
    logic        pin_oe_reg;
    logic        pin_oe_next;
    logic        gpio_out_reg;
    logic        gpio_out_next;

    // ---------------- combinational helpers ----------------
    logic [15:0] raw_lvl;
    logic [15:0] cond;
    logic [15:0] edge_hit;
    logic        tick32;
    logic        fll_tick;
    logic        addr_take;
    logic [15:0] wr_half;
    logic        sts1;
    logic        sts2;
    logic        pin_level;

    assign hreadyout = hreadyout_reg;
    assign hresp = hresp_reg;
    assign hrdata = hrdata_reg;
    assign first_request_output = req1_reg;
    assign second_request_output = req2_reg;
    assign irq_pin_out = pin_out_reg;
    assign irq_pin_oe = pin_oe_reg;
    assign gpio_req_out = gpio_out_reg;
    assign dsp_fw_trigger = req2_reg;

    // input conditioning and edge detection
    always_comb begin
        raw_lvl = raw_vec(src_in);
        tick32 = clk32k & ~clk32_prev_reg;
        // lock filter ticks on 32k or system clock
        fll_tick = tick32 | sysclk_on;
        clk32_prev_next = clk32k;
        for (int i = 0; i < NUM_DEB; i++) begin
            deb_next[i] = deb_reg[i];
        end
        for (int i = 0; i < NUM_GPIO; i++) begin
            deb_next[i] = deb_step(deb_reg[i], src_in.gpio[i], tick32);
        end
        for (int i = 0; i < 2; i++) begin
            deb_next[DEB_FLL_LSB + i] = deb_step(deb_reg[DEB_FLL_LSB + i], src_in.fll_lock[i], fll_tick);
        end
        cond = raw_lvl;
        // fall flags see inverted jack level
        cond[SRC_JACK1_FALL] = ~src_in.jack_detect_one;
        cond[SRC_JACK2_FALL] = ~src_in.jack_detect_two;
        for (int i = 0; i < NUM_GPIO; i++) begin
            if (ctrl_reg[CTRL_DEB_LSB + i]) begin
                cond[SRC_GPIO_LSB + i] = deb_reg[i].val;
            end
        end
        for (int i = 0; i < 2; i++) begin
            cond[SRC_FLL_LSB + i] = deb_reg[DEB_FLL_LSB + i].val;
        end
        prev_next = cond;
        // rising edges, plus falling for both-edge inputs
        // both directions merge into one flag
        // logger not-empty rise flags an event
        edge_hit = (cond & ~prev_reg) | (~cond & prev_reg & BOTH_EDGE_SEL);
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            prev_reg <= '0;
            clk32_prev_reg <= 1'b0;
            for (int i = 0; i < NUM_DEB; i++) begin
                deb_reg[i] <= '0;
            end
        end else if (ce) begin
            prev_reg <= prev_next;
            clk32_prev_reg <= clk32_prev_next;
            for (int i = 0; i < NUM_DEB; i++) begin
                deb_reg[i] <= deb_next[i];
            end
        end
    end

    // ahb-lite slave sequencing
    always_comb begin
        addr_take = hsel & htrans[1] & hready;
        wr_pend_next = addr_take & hwrite;
        rd_pend_next = addr_take & ~hwrite;
        wr_addr_next = addr_take ? haddr[7:0] : wr_addr_reg;
        rd_addr_next = addr_take ? haddr[7:0] : rd_addr_reg;
        // reads take one wait state so pending writes land first
        hreadyout_next = ~(addr_take & ~hwrite);
        // every transfer answers okay
        hresp_next = 1'b0;
        hrdata_next = hrdata_reg;
        if (rd_pend_reg) begin
            unique case (rd_addr_reg)
                ADDR_FLAG1: hrdata_next = {16'h0000, flag1_reg};
                ADDR_MASK1: hrdata_next = {16'h0000, mask1_reg};
                ADDR_FLAG2: hrdata_next = {16'h0000, flag2_reg};
                ADDR_MASK2: hrdata_next = {16'h0000, mask2_reg};
                // one raw view for both sets
                // raw view bypasses the debounce filters
                ADDR_RAW: hrdata_next = {16'h0000, raw_lvl};
                ADDR_CTRL: hrdata_next = {22'h000000, ctrl_reg};
                ADDR_STATUS: hrdata_next = {30'h00000000, req2_reg, req1_reg};
                default: hrdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rd_addr_reg <= 8'h00;
            hrdata_reg <= 32'h00000000;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end else if (ce) begin
            wr_pend_reg <= wr_pend_next;
            rd_pend_reg <= rd_pend_next;
            wr_addr_reg <= wr_addr_next;
            rd_addr_reg <= rd_addr_next;
            hrdata_reg <= hrdata_next;
            hreadyout_reg <= hreadyout_next;
            hresp_reg <= hresp_next;
        end
    end

    // flag, mask and control registers
    always_comb begin
        wr_half = hwdata[15:0];
        mask1_next = mask1_reg;
        mask2_next = mask2_reg;
        ctrl_next = ctrl_reg;
        flag1_next = flag1_reg;
        flag2_next = flag2_reg;
        if (wr_pend_reg) begin
            unique case (wr_addr_reg)
                ADDR_FLAG1: flag1_next = flag1_reg & ~wr_half;
                ADDR_FLAG2: flag2_next = flag2_reg & ~wr_half;
                ADDR_MASK1: mask1_next = wr_half;
                ADDR_MASK2: mask2_next = wr_half;
                ADDR_CTRL: ctrl_next = hwdata[9:0];
                default: ;
            endcase
        end
        flag1_next = set_hits(flag1_next, edge_hit, mask1_reg);
        flag2_next = set_hits(flag2_next, edge_hit, mask2_reg);
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            flag1_reg <= FLAG_RST;
            flag2_reg <= FLAG_RST;
            mask1_reg <= MASK1_RST;
            mask2_reg <= MASK2_RST;
            ctrl_reg <= CTRL_RST;
        end else if (ce) begin
            flag1_reg <= flag1_next;
            flag2_reg <= flag2_next;
            mask1_reg <= mask1_next;
            mask2_reg <= mask2_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // request outputs and pin drive
    always_comb begin
        // global mask gates output and status
        sts1 = set_req(flag1_reg, ctrl_reg[CTRL_GM1]);
        sts2 = set_req(flag2_reg, ctrl_reg[CTRL_GM2]);
        req1_next = sts1;
        req2_next = sts2;
        // active low unless polarity bit set
        pin_level = ctrl_reg[CTRL_POL] ? sts1 : ~sts1;
        if (ctrl_reg[CTRL_OD]) begin
            pin_out_next = 1'b0;
            pin_oe_next = ~pin_level;
        end else begin
            pin_out_next = pin_level;
            pin_oe_next = 1'b1;
        end
        unique case (ctrl_reg[CTRL_GPFN_LSB +: 2])
            GPFN_FIRST: gpio_out_next = sts1;
            GPFN_SECOND: gpio_out_next = sts2;
            default: gpio_out_next = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            req1_reg <= 1'b0;
            req2_reg <= 1'b0;
            pin_out_reg <= 1'b1;
            pin_oe_reg <= 1'b1;
            gpio_out_reg <= 1'b0;
        end else if (ce) begin
            req1_reg <= req1_next;
            req2_reg <= req2_next;
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
            gpio_out_reg <= gpio_out_next;
        end
    end

endmodule

`default_nettype wire

//--- host_model.sv
// host side of the request pin with its pull-up
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic irq_pin_out,
    input  wire logic irq_pin_oe,
    output logic      pin_level
);
    assign pin_level = irq_pin_oe ? irq_pin_out : 1'b1;
endmodule
`default_nettype wire

//--- irq_ctrl_assertions.sv
// port checker for the request controller
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_chk
    import irq_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        first_request_output,
    input wire logic        second_request_output,
    input wire logic        irq_pin_out,
    input wire logic        irq_pin_oe,
    input wire logic        gpio_req_out,
    input wire logic        dsp_fw_trigger
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic       tk;
    logic [2:0] age_reg;
    logic [2:0] age_next;
    assign tk = hsel & htrans[1] & hready & ce;
    always_comb begin
        age_next = (age_reg == 3'h7) ? age_reg : age_reg + 3'h1;
        if (tk && hwrite)
            age_next = 3'h0;
    end
    always_ff @(posedge core_clk) begin
        age_reg <= nrst ? age_next : 3'h0;
    end
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_rd_wait; tk && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_wr_fast; tk && hwrite |=> hreadyout; endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
    property p_upper; $rose(hreadyout) |-> hrdata[31:16] == 16'h0000; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_fw; dsp_fw_trigger == second_request_output; endproperty
    a_fw: assert property (p_fw) else $error("firmware trigger differs");
    property p_od; !irq_pin_oe |-> !irq_pin_out; endproperty
    a_od: assert property (p_od) else $error("released pin drives high");
    property p_gpio; gpio_req_out |-> first_request_output || second_request_output; endproperty
    a_gpio: assert property (p_gpio) else $error("gpio request without source");
    property p_fall; $fell(first_request_output) || $fell(second_request_output) |-> age_reg <= 3'h3; endproperty
    a_fall: assert property (p_fall) else $error("request dropped without write");
    property p_rst_pin; $rose(nrst) |-> irq_pin_out && irq_pin_oe && !first_request_output; endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("pin active after reset");
    c_read: cover property (tk && !hwrite);
    c_fall: cover property ($fell(first_request_output));
    c_od: cover property (!irq_pin_oe);
    c_gpio: cover property (gpio_req_out);
endmodule
bind irq_ctrl irq_ctrl_chk u_chk (.core_clk(core_clk), .nrst(nrst), .ce(ce), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .first_request_output(first_request_output),
    .second_request_output(second_request_output), .irq_pin_out(irq_pin_out),
    .irq_pin_oe(irq_pin_oe), .gpio_req_out(gpio_req_out), .dsp_fw_trigger(dsp_fw_trigger));
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the request controller
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import irq_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        clk32k = 1'b0;
    logic        sysclk_on = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] rd;
    src_in_t     src = '0;
    logic [9:0]  tc [7] = '{10'h000, 10'h004, 10'h008, 10'h00c, 10'h100, 10'h200, 10'h300};
    logic [1:0]  te [7] = '{2'h0, 2'h2, 2'h0, 2'h2, 2'h1, 2'h0, 2'h0};
    wire logic   hreadyout, hresp, first_o, second_o, pin_out, pin_oe, gpio_o, fw_o, pin;
    wire logic [31:0] hrdata;
    int          err_count = 0;
    int          check_count = 0;
    irq_ctrl dut (.core_clk(core_clk), .nrst(nrst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src_in(src), .clk32k(clk32k),
        .sysclk_on(sysclk_on), .first_request_output(first_o), .second_request_output(second_o),
        .irq_pin_out(pin_out), .irq_pin_oe(pin_oe), .gpio_req_out(gpio_o), .dsp_fw_trigger(fw_o));
    host_model host (.irq_pin_out(pin_out), .irq_pin_oe(pin_oe), .pin_level(pin));
    always #5 core_clk = ~core_clk;
    task close_out;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task wait_hr;
        int n;
        n = 0;
        @(negedge core_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 40) begin
                err_count++;
                close_out;
            end
            @(negedge core_clk);
        end
        rd = hrdata;
        @(posedge core_clk);
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        wait_hr;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_hr;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task wait_req(input int s, input logic v);
        int n;
        for (n = 0; n < 60; n++) begin
            @(negedge core_clk);
            if ((s == 0 ? first_o : second_o) === v)
                break;
        end
        if (n == 60) begin
            err_count++;
            close_out;
        end
        @(posedge core_clk);
    endtask
    task s_reset;
        rdc(ADDR_MASK1, {16'h0, MASK1_RST});
        rdc(ADDR_MASK2, {16'h0, MASK2_RST});
        rdc(ADDR_FLAG1, {16'h0, FLAG_RST});
        rdc(ADDR_CTRL, {22'h0, CTRL_RST});
        rdc(8'h1c, 32'h0);
        chk({31'h0, pin}, 32'h1);
    endtask
    task s_boot;
        src.boot_done <= 1'b1;
        wait_req(0, 1'b1);
        chk({31'h0, pin}, 32'h0);
        rdc(ADDR_FLAG1, 32'h400);
        rdc(ADDR_FLAG2, 32'h0);
        wr(ADDR_FLAG1, 32'h0);
        rdc(ADDR_FLAG1, 32'h400);
        wr(ADDR_FLAG1, 32'h400);
        wait_req(0, 1'b0);
        rdc(ADDR_FLAG1, 32'h0);
    endtask
    task s_sets;
        wr(ADDR_MASK1, 32'hff);
        wr(ADDR_MASK2, 32'h0);
        src <= '{1'b1, 1'b1, 4'hf, 2'h0, 1'b1, 2'h3, 1'b1, 2'h3};
        repeat (3) @(posedge core_clk);
        rdc(ADDR_FLAG2, 32'hf8f5);
        rdc(ADDR_FLAG1, 32'hf800);
        rdc(ADDR_RAW, 32'hfcff);
        rdc(ADDR_STATUS, 32'h3);
        chk({31'h0, fw_o}, 32'h1);
        wr(ADDR_CTRL, 32'h2);
        wait_req(1, 1'b0);
        chk({31'h0, fw_o}, 32'h0);
        rdc(ADDR_STATUS, 32'h1);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_FLAG2, 32'hffff);
        src <= '{1'b0, 1'b0, 4'h0, 2'h0, 1'b1, 2'h3, 1'b1, 2'h3};
        repeat (3) @(posedge core_clk);
        rdc(ADDR_FLAG2, 32'hfa);
        wr(ADDR_FLAG1, 32'hffff);
        wr(ADDR_FLAG2, 32'hffff);
        wait_req(0, 1'b0);
        wait_req(1, 1'b0);
    endtask
    task s_pin;
        int i;
        wr(ADDR_MASK1, 32'hffef);
        wr(ADDR_MASK2, 32'hffff);
        src.gpio <= 4'h1;
        wait_req(0, 1'b1);
        for (i = 0; i < 7; i++) begin
            wr(ADDR_CTRL, {22'h0, tc[i]});
            repeat (2) @(negedge core_clk);
            chk({30'h0, pin, gpio_o}, {30'h0, te[i]});
            @(posedge core_clk);
        end
        chk({31'h0, second_o}, 32'h0);
        // falling gpio edge lands in the clearing write's data phase
        fork
            wr(ADDR_FLAG1, 32'h10);
            begin
                @(posedge core_clk);
                src.gpio <= 4'h0;
            end
        join
        rdc(ADDR_FLAG1, 32'h10);
        wr(ADDR_FLAG1, 32'h10);
        wait_req(0, 1'b0);
        chk({31'h0, pin}, 32'h1);
    endtask
    task s_lock;
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_MASK2, 32'h0);
        sysclk_on <= 1'b1;
        src.fll_lock <= 2'h1;
        wait_req(1, 1'b1);
        rdc(ADDR_FLAG2, 32'h100);
        wr(ADDR_FLAG2, 32'h100);
        sysclk_on <= 1'b0;
        src.fll_lock <= 2'h0;
        repeat (30) @(posedge core_clk);
        rdc(ADDR_RAW, 32'hfc00);
        rdc(ADDR_FLAG2, 32'h0);
        repeat (12) begin
            clk32k <= ~clk32k;
            repeat (3) @(posedge core_clk);
        end
        wait_req(1, 1'b1);
        rdc(ADDR_FLAG2, 32'h100);
        wr(ADDR_FLAG2, 32'h100);
        wr(ADDR_CTRL, 32'h10);
        src.gpio <= 4'h1;
        repeat (20) @(posedge core_clk);
        rdc(ADDR_FLAG2, 32'h0);
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        s_reset;
        s_boot;
        s_sets;
        s_pin;
        s_lock;
        close_out;
    end
endmodule
`default_nettype wire
